/* File: src/ccdp_channel_divider.sv */
// Channel clock dividers with coarse phase delay, cascaded stages and output driver modes

// One divide stage: low phase, high phase, optional start delay
module ccdp_stage (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Control
  input  wire logic       adv_i,
  input  wire logic       restart_i,
  input  wire logic       bypass_i,
  input  wire logic [3:0] low_i,
  input  wire logic [3:0] high_i,
  input  wire logic [4:0] delay_i,
  // Result
  output logic            level_o,
  output logic            rise_o
);
  import ccdp_pkg::*;

  typedef enum {ST_DELAY, ST_LOW, ST_HIGH} ccdp_state_t;

  ccdp_state_t state_q;
  logic [4:0]  cnt_q;
  logic        level_q;

  // Bypass holds the counter idle, as if powered down
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= ST_LOW;
      cnt_q   <= 5'h00;
      level_q <= 1'b0;
    end else if (restart_i || bypass_i) begin
      level_q <= 1'b0;
      if (delay_i == 5'h00) begin
        state_q <= ST_LOW;
        cnt_q   <= {1'b0, low_i};
      end else begin
        state_q <= ST_DELAY;
        cnt_q   <= 5'(delay_i - 5'h01);
      end
    end else if (adv_i) begin
      case (state_q)
        ST_DELAY: begin
          if (cnt_q == 5'h00) begin
            state_q <= ST_LOW;
            cnt_q   <= {1'b0, low_i};
          end else begin
            cnt_q <= 5'(cnt_q - 5'h01);
          end
        end
        ST_LOW: begin
          if (cnt_q == 5'h00) begin
            state_q <= ST_HIGH;
            cnt_q   <= {1'b0, high_i};
            level_q <= 1'b1;
          end else begin
            cnt_q <= 5'(cnt_q - 5'h01);
          end
        end
        ST_HIGH: begin
          if (cnt_q == 5'h00) begin
            state_q <= ST_LOW;
            cnt_q   <= {1'b0, low_i};
            level_q <= 1'b0;
          end else begin
            cnt_q <= 5'(cnt_q - 5'h01);
          end
        end
        default: begin
          state_q <= ST_LOW;
          cnt_q   <= 5'h00;
          level_q <= 1'b0;
        end
      endcase
    end
  end

  assign level_o = level_q;
  assign rise_o  = adv_i && !bypass_i && !restart_i && (state_q == ST_LOW) && (cnt_q == 5'h00);

endmodule

module ccdp_channel_divider (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  // Avalon-MM slave
  input  wire ccdp_pkg::ccdp_av_req_t avs_req_i,
  output ccdp_pkg::ccdp_av_rsp_t      avs_rsp_o,
  // Channel outputs, one level per input cycle
  output logic [4:0]                  ch_level_o,
  output logic [4:0]                  ch_pass_o,
  // Cascaded channel drivers, outputs first..last
  output logic [3:0]                  drv_a_o,
  output logic [3:0]                  drv_b_o,
  output logic [3:0]                  drv_b_en_o,
  output logic [1:0]                  duty_cycle_fix_o
);
  import ccdp_pkg::*;

  logic [7:0]       regs_q [0:REG_COUNT-1];
  logic [IDX_W-1:0] idx;
  logic             hit_store;
  logic             hit_sync;
  logic             hit_status;
  logic [4:0]       slot;
  logic             ack_q;
  logic [31:0]      rdata_q;
  logic             take_wr;
  logic             sync_q;
  logic [4:0]       lvl_d;
  logic [4:0]       pass_d;
  logic [4:0]       lvl_q;
  logic [4:0]       pass_q;
  logic [3:0]       drv_a_q;
  logic [3:0]       drv_b_q;
  logic [3:0]       drv_b_en_q;
  logic [1:0]       dcc_q;

  // Decode: table registers plus output mode hold storage; gaps read zero
  function automatic logic is_stored(input logic [8:0] i);
    case (i)
      IDX_CH0_COUNTS, IDX_CH0_PHASE, IDX_CH1_COUNTS, IDX_CH1_PHASE,
      IDX_CH2_COUNTS, IDX_CH2_PHASE, IDX_CH3_STAGE1, IDX_CH3_STAGE2,
      IDX_CH3_BYPASS, IDX_CH3_DUTY_FIX, IDX_CH4_STAGE1, IDX_CH4_STAGE2,
      IDX_CH4_BYPASS, IDX_CH4_DUTY_FIX, IDX_OUT_MODE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Returns a slot, not the stored byte, so each assign below stays sensitive to the storage
  function automatic logic [4:0] slot_of(input logic [8:0] i);
    return 5'(i - IDX_FIRST);
  endfunction

  // Count fields of one divide stage
  function automatic logic [3:0] low_field(input logic [7:0] r);
    return r[LOW_MSB:LOW_LSB];
  endfunction

  function automatic logic [3:0] high_field(input logic [7:0] r);
    return r[HIGH_MSB:HIGH_LSB];
  endfunction

  // Status word: duty fix flags, pass flags, channel levels
  function automatic logic [31:0] status_word(input logic [1:0] f, input logic [4:0] p, input logic [4:0] l);
    return {20'h0_0000, f, p, l};
  endfunction

  assign idx        = avs_req_i.address[ADDR_W-1:2];
  assign hit_store  = is_stored(idx);
  assign hit_sync   = (idx == IDX_SYNC_CTRL);
  assign hit_status = (idx == IDX_STATUS);
  assign slot       = slot_of(idx);

  // One wait cycle on every access keeps read data registered
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_req_i.read || avs_req_i.write) && !ack_q;
    end
  end

  assign avs_rsp_o.waitrequest = (avs_req_i.read || avs_req_i.write) && !ack_q;
  assign avs_rsp_o.readdata    = rdata_q;
  // Writes land only on the answering edge, so a held request is stored once
  assign take_wr = avs_req_i.write && ack_q && avs_req_i.byteenable[0];

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_req_i.read && !ack_q) begin
      if (hit_store) begin
        rdata_q <= {24'h00_0000, regs_q[slot]};
      end else if (hit_status) begin
        rdata_q <= status_word(dcc_q, pass_q, lvl_q);
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // Register storage; reset leaves duty fix on and every output pair differential with its B side enabled
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (take_wr && hit_store) begin
      regs_q[slot] <= avs_req_i.writedata[7:0];
    end
  end

  // Synchronization pulse; offsets are loaded here and while a stage is bypassed
  // Reset also raises it, so every counter starts from one reference edge
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync_q <= 1'b1;
    end else begin
      sync_q <= take_wr && hit_sync && avs_req_i.writedata[SYNC_BIT];
    end
  end

  // Single-stage channels 0 to 2
  logic [2:0] s_lvl;
  logic [2:0] s_byp;
  logic [7:0] s_cnt [0:2];
  logic [7:0] s_phs [0:2];

  assign s_cnt[0] = regs_q[slot_of(IDX_CH0_COUNTS)];
  assign s_phs[0] = regs_q[slot_of(IDX_CH0_PHASE)];
  assign s_cnt[1] = regs_q[slot_of(IDX_CH1_COUNTS)];
  assign s_phs[1] = regs_q[slot_of(IDX_CH1_PHASE)];
  assign s_cnt[2] = regs_q[slot_of(IDX_CH2_COUNTS)];
  assign s_phs[2] = regs_q[slot_of(IDX_CH2_PHASE)];

  for (genvar c = 0; c < 3; c++) begin : g_single
    assign s_byp[c] = s_phs[c][SINGLE_BYPASS_BIT];
    ccdp_stage u_stage (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .adv_i     (1'b1),
      .restart_i (sync_q),
      .bypass_i  (s_byp[c]),
      .low_i     (low_field(s_cnt[c])),
      .high_i    (high_field(s_cnt[c])),
      .delay_i   (ccdp_delay(s_phs[c], low_field(s_cnt[c]))),
      .level_o   (s_lvl[c]),
      .rise_o    ()
    );
  end

  // Cascaded channels 3 and 4; the second stage counts first-stage periods
  logic [1:0] c_lvl1;
  logic [1:0] c_lvl2;
  logic [1:0] c_rise1;
  logic [1:0] c_byp1;
  logic [1:0] c_byp2;
  logic [7:0] c_st1 [0:1];
  logic [7:0] c_st2 [0:1];
  logic [7:0] c_bp  [0:1];
  logic [7:0] c_dfx [0:1];

  assign c_st1[0] = regs_q[slot_of(IDX_CH3_STAGE1)];
  assign c_st2[0] = regs_q[slot_of(IDX_CH3_STAGE2)];
  assign c_bp[0]  = regs_q[slot_of(IDX_CH3_BYPASS)];
  assign c_dfx[0] = regs_q[slot_of(IDX_CH3_DUTY_FIX)];
  assign c_st1[1] = regs_q[slot_of(IDX_CH4_STAGE1)];
  assign c_st2[1] = regs_q[slot_of(IDX_CH4_STAGE2)];
  assign c_bp[1]  = regs_q[slot_of(IDX_CH4_BYPASS)];
  assign c_dfx[1] = regs_q[slot_of(IDX_CH4_DUTY_FIX)];

  for (genvar c = 0; c < 2; c++) begin : g_cascade
    assign c_byp1[c] = c_bp[c][STAGE1_BYPASS_BIT];
    assign c_byp2[c] = c_bp[c][STAGE2_BYPASS_BIT];
    ccdp_stage u_first (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .adv_i     (1'b1),
      .restart_i (sync_q),
      .bypass_i  (c_byp1[c]),
      .low_i     (low_field(c_st1[c])),
      .high_i    (high_field(c_st1[c])),
      .delay_i   (5'h00),
      .level_o   (c_lvl1[c]),
      .rise_o    (c_rise1[c])
    );
    // A bypassed first stage feeds every input cycle onward, though software avoids this
    ccdp_stage u_second (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .adv_i     (c_byp1[c] ? 1'b1 : c_rise1[c]),
      .restart_i (sync_q),
      .bypass_i  (c_byp2[c]),
      .low_i     (low_field(c_st2[c])),
      .high_i    (high_field(c_st2[c])),
      .delay_i   (5'h00),
      .level_o   (c_lvl2[c]),
      .rise_o    ()
    );
  end

  // Output selection; a pass flag means the pin follows the input clock itself
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      pass_d[c] = s_byp[c];
      lvl_d[c]  = s_byp[c] ? 1'b0 : s_lvl[c];
    end
    for (int c = 0; c < 2; c++) begin
      if (c_byp1[c] && c_byp2[c]) begin
        pass_d[3+c] = 1'b1;
        lvl_d[3+c]  = 1'b0;
      end else if (c_byp2[c]) begin
        pass_d[3+c] = 1'b0;
        lvl_d[3+c]  = c_lvl1[c];
      end else begin
        pass_d[3+c] = 1'b0;
        lvl_d[3+c]  = c_lvl2[c];
      end
    end
  end

  // Drivers: differential pairs or split A/B single-ended outputs
  logic [7:0] out_mode;
  assign out_mode = regs_q[slot_of(IDX_OUT_MODE)];

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lvl_q  <= 5'h00;
      pass_q <= 5'h00;
    end else begin
      lvl_q  <= lvl_d;
      pass_q <= pass_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      drv_a_q    <= 4'h0;
      drv_b_q    <= 4'h0;
      drv_b_en_q <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        drv_a_q[k] <= lvl_d[3 + k/2];
        // A disabled B side is held low, never left floating
        if (out_mode[SE_MODE_LSB+k]) begin
          drv_b_en_q[k] <= out_mode[B_EN_LSB+k];
          drv_b_q[k]    <= out_mode[B_EN_LSB+k] & lvl_d[3 + k/2];
        end else begin
          drv_b_en_q[k] <= 1'b1;
          drv_b_q[k]    <= ~lvl_d[3 + k/2];
        end
      end
    end
  end

  // Duty fix cannot add the half input cycle that odd ratios need at this rate
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dcc_q <= 2'b11;
    end else begin
      dcc_q <= {~c_dfx[1][DUTY_FIX_DISABLE_BIT], ~c_dfx[0][DUTY_FIX_DISABLE_BIT]};
    end
  end

  assign ch_level_o       = lvl_q;
  assign ch_pass_o        = pass_q;
  assign drv_a_o          = drv_a_q;
  assign drv_b_o          = drv_b_q;
  assign drv_b_en_o       = drv_b_en_q;
  assign duty_cycle_fix_o = dcc_q;

endmodule

/* File: src/ccdp_pkg.sv */
// Package: register map, field positions, reset values and bus carriers of the channel divider block
package ccdp_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W   = 11;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 9;

  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_CH0_COUNTS    = 9'h190;
  localparam logic [8:0] IDX_CH0_PHASE     = 9'h191;
  localparam logic [8:0] IDX_CH1_COUNTS    = 9'h193;
  localparam logic [8:0] IDX_CH1_PHASE     = 9'h194;
  localparam logic [8:0] IDX_CH2_COUNTS    = 9'h196;
  localparam logic [8:0] IDX_CH2_PHASE     = 9'h197;
  localparam logic [8:0] IDX_CH3_STAGE1    = 9'h199;
  localparam logic [8:0] IDX_CH3_STAGE2    = 9'h19b;
  localparam logic [8:0] IDX_CH3_BYPASS    = 9'h19c;
  localparam logic [8:0] IDX_CH3_DUTY_FIX  = 9'h19d;
  localparam logic [8:0] IDX_CH4_STAGE1    = 9'h19e;
  localparam logic [8:0] IDX_CH4_STAGE2    = 9'h1a0;
  localparam logic [8:0] IDX_CH4_BYPASS    = 9'h1a1;
  localparam logic [8:0] IDX_CH4_DUTY_FIX  = 9'h1a2;
  localparam logic [8:0] IDX_OUT_MODE      = 9'h1a3;
  localparam logic [8:0] IDX_SYNC_CTRL     = 9'h1a4;
  localparam logic [8:0] IDX_STATUS        = 9'h1a5;

  // Storage window covers indices first..last
  localparam logic [8:0] IDX_FIRST        = 9'h190;
  localparam int unsigned REG_COUNT       = 20;

  // Field positions
  localparam int unsigned LOW_MSB          = 7;
  localparam int unsigned LOW_LSB          = 4;
  localparam int unsigned HIGH_MSB         = 3;
  localparam int unsigned HIGH_LSB         = 0;
  localparam int unsigned INIT_LEVEL_BIT   = 4;
  localparam int unsigned PHASE_DELAY_MSB  = 3;
  localparam int unsigned SINGLE_BYPASS_BIT = 7;
  localparam int unsigned STAGE1_BYPASS_BIT = 4;
  localparam int unsigned STAGE2_BYPASS_BIT = 5;
  localparam int unsigned DUTY_FIX_DISABLE_BIT = 0;
  localparam int unsigned SYNC_BIT         = 0;
  localparam int unsigned SE_MODE_LSB      = 0;
  localparam int unsigned B_EN_LSB         = 4;

  // Reset value of every stored register
  localparam logic [7:0] REG_RESET         = 8'h00;

  // Delay selector threshold
  localparam logic [5:0] SEL_SPLIT         = 6'h10;

  // Avalon-MM carriers
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [3:0]        byteenable;
  } ccdp_av_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
  } ccdp_av_rsp_t;

  // Delay in input cycles from initial-level bit, phase delay field and low count
  function automatic logic [4:0] ccdp_delay(input logic [7:0] phase_ctrl, input logic [3:0] low_cnt);
    logic [5:0] sel;
    logic [5:0] dly;
    sel = {1'b0, phase_ctrl[INIT_LEVEL_BIT], phase_ctrl[PHASE_DELAY_MSB:0]};
    if (sel < SEL_SPLIT) begin
      dly = sel;
    end else begin
      dly = 6'(sel - SEL_SPLIT + {2'b00, low_cnt} + 6'h01);
    end
    return dly[4:0];
  endfunction

endpackage

/* File: tb/ccdp_checker.sv */
// Checker: bus handshake and output relations of the channel divider
module ccdp_checker
  import ccdp_pkg::*;
(
  // Clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   sys_rst_i,
  // Bus
  input wire ccdp_pkg::ccdp_av_req_t avs_req_i,
  input wire ccdp_pkg::ccdp_av_rsp_t avs_rsp_o,
  // Outputs
  input wire logic [4:0]             ch_level_o,
  input wire logic [4:0]             ch_pass_o,
  input wire logic [3:0]             drv_a_o,
  input wire logic [3:0]             drv_b_o,
  input wire logic [3:0]             drv_b_en_o,
  input wire logic [1:0]             duty_cycle_fix_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       req;
  logic [5:0] hi_q;
  assign req = avs_req_i.read | avs_req_i.write;
  // High run of channel 0; too long to unroll as a repetition
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) hi_q <= 6'h00;
    else hi_q <= ch_level_o[0] ? hi_q + 6'h01 : 6'h00;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_req_new;
    req && !$past(req);
  endsequence
  a_wait_first: assert property (s_req_new |-> avs_rsp_o.waitrequest)
    else $error("no wait cycle on new request");
  a_wait_one: assert property (s_req_new |-> ##1 !avs_rsp_o.waitrequest)
    else $error("request not answered after one wait");
  a_idle_nowait: assert property (!req |-> !avs_rsp_o.waitrequest)
    else $error("wait without request");
  a_rdata_upper: assert property (avs_req_i.read && !avs_rsp_o.waitrequest |-> avs_rsp_o.readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_pass_low: assert property ((ch_pass_o & ch_level_o) == 5'h00)
    else $error("bypassed channel shows level");
  a_b_gated: assert property ((~drv_b_en_o & drv_b_o) == 4'h0)
    else $error("disabled B side driven");
  a_fix_reset: assert property ($fell(sys_rst_i) |-> duty_cycle_fix_o == 2'b11)
    else $error("duty fix off after reset");
  a_high_max: assert property (hi_q <= 6'h10)
    else $error("high run above sixteen");
  a_drv_a_follow: assert property (drv_a_o == {ch_level_o[4], ch_level_o[4], ch_level_o[3], ch_level_o[3]})
    else $error("A side differs from channel level");
endmodule

/* File: tb/channel_clock_divider_phase_tb.sv */
// Testbench: registers, phase delay, hold until sync, cascaded division, driver modes
module channel_clock_divider_phase_tb import ccdp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_sys_i;
  logic         sys_rst_i;
  ccdp_av_req_t req;
  ccdp_av_rsp_t rsp;
  logic [4:0]   lvl;
  logic [4:0]   pas;
  logic [3:0]   db;
  logic [3:0]   da;
  logic [3:0]   dbe;
  logic [1:0]   fix;
  logic [31:0]  rd;
  logic [7:0]   m;
  logic [7:0]   n;
  logic [7:0]   s;
  logic [7:0]   v;
  logic [8:0]   o;
  int           num_errors;
  int           cmp_count;
  int           seed;
  int           dt;
  int           h;
  int           p;
  int           e;
  logic [8:0]   regs [14] = '{9'h190, 9'h191, 9'h193, 9'h194, 9'h196, 9'h197, 9'h199,
                              9'h19b, 9'h19c, 9'h19d, 9'h19e, 9'h1a0, 9'h1a1, 9'h1a2};
  logic [7:0]   sels [4] = '{8'h0f, 8'h10, 8'h1f, 8'h00};

  ccdp_channel_divider ccdp_channel_divider_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_req_i(req), .avs_rsp_o(rsp),
    .ch_level_o(lvl), .ch_pass_o(pas), .drv_a_o(da), .drv_b_o(db), .drv_b_en_o(dbe),
    .duty_cycle_fix_o(fix));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task summarize;
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus cycle; held until waitrequest is seen low
  task bus(input logic wr, input logic [8:0] idx, input logic [7:0] wd);
    int i;
    @(posedge clk_sys_i);
    req <= '{address: {idx, 2'b00}, read: !wr, write: wr, writedata: {24'h0, wd}, byteenable: 4'hf};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (rsp.waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      chk("wait", 1, 0);
      summarize();
    end
    rd = rsp.readdata;
    req <= '0;
  endtask

  task sync;
    bus(1'b1, IDX_SYNC_CTRL, 8'h01);
  endtask

  // Cycles from a rise of channel 1 to the next rise of channel 0
  task gap(output int g);
    int i;
    int a;
    int b;
    logic [4:0] pv;
    a = -1;
    b = -1;
    pv = '1;
    for (i = 0; i < 400 && b < 0; i++) begin
      @(posedge clk_sys_i);
      if (i >= 3 && a < 0 && lvl[1] && !pv[1]) a = i;
      if (a >= 0 && lvl[0] && !pv[0]) b = i;
      pv = lvl;
    end
    if (b < 0) chk("rise", 1, 0);
    g = b - a;
  endtask

  // High cycles and period of channel c
  task edges(input int c, output int hh, output int pp);
    int i;
    int t;
    logic pv;
    t = -1;
    hh = 0;
    pp = 0;
    pv = 1'b1;
    for (i = 0; i < 3000 && pp == 0; i++) begin
      @(posedge clk_sys_i);
      if (i >= 3 && lvl[c] && !pv) begin
        if (t >= 0) pp = i - t;
        else t = i;
      end
      if (t >= 0 && pp == 0 && lvl[c]) hh++;
      pv = lvl[c];
    end
    if (pp == 0) chk("period", 1, 0);
  endtask

  initial begin
    seed = 32'h7c3f;
    num_errors = 0;
    cmp_count = 0;
    req = '0;
    sys_rst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("fix", 32'(fix), 32'h3);
    foreach (regs[i]) begin
      v = 8'($random(seed));
      bus(1'b0, regs[i], 8'h00);
      chk("reset", rd, 32'h0);
      bus(1'b1, regs[i], v);
      bus(1'b0, regs[i], 8'h00);
      chk("readback", rd, {24'h0, v});
    end
    bus(1'b1, 9'h1ff, 8'hff);
    bus(1'b0, 9'h1ff, 8'h00);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, IDX_CH3_DUTY_FIX, 8'h01);
    bus(1'b1, IDX_CH4_DUTY_FIX, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    chk("fix", 32'(fix), 32'h2);
    // Second reset in mid-run must restore defaults
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("fix", 32'(fix), 32'h3);
    // Long high phase keeps every delay inside one period
    foreach (sels[k]) begin
      m = 8'($random(seed)) & 8'h0f;
      s = (k == 3) ? 8'($random(seed)) & 8'h1f : sels[k];
      bus(1'b1, IDX_CH0_COUNTS, {m[3:0], 4'hf});
      bus(1'b1, IDX_CH1_COUNTS, {m[3:0], 4'hf});
      bus(1'b1, IDX_CH0_PHASE, s);
      bus(1'b1, IDX_CH1_PHASE, 8'h00);
      sync();
      e = (s < 16) ? int'(s) : int'(s) - 16 + int'(m) + 1;
      gap(dt);
      chk("delay", dt, e);
      bus(1'b1, IDX_CH0_PHASE, 8'($random(seed)) & 8'h1f);
      gap(dt);
      chk("held", dt, e % (int'(m) + 17));
      edges(0, h, p);
      chk("high", h, 16);
      chk("ratio", p, int'(m) + 17);
    end
    for (int c = 3; c < 5; c++) begin
      o = 9'((c - 3) * 5);
      v = 8'($random(seed));
      m = {4'({1'b0, v[2:0]} + {3'b000, v[3]}), 1'b0, v[2:0]};
      v = 8'($random(seed));
      n = {4'({2'b00, v[1:0]} + {3'b000, v[2]}), 2'b00, v[1:0]};
      bus(1'b1, IDX_CH3_STAGE1 + o, m);
      bus(1'b1, IDX_CH3_STAGE2 + o, n);
      bus(1'b1, IDX_CH3_BYPASS + o, 8'h20);
      sync();
      edges(c, h, p);
      chk("stage", p, m[7:4] + m[3:0] + 2);
      chk("stage_high", h, m[3:0] + 1);
      bus(1'b1, IDX_CH3_BYPASS + o, 8'h00);
      sync();
      edges(c, h, p);
      chk("cascade", p, (m[7:4] + m[3:0] + 2) * (n[7:4] + n[3:0] + 2));
      chk("cascade_high", h, (n[3:0] + 1) * (m[7:4] + m[3:0] + 2));
      bus(1'b1, IDX_CH3_BYPASS + o, 8'h30);
      sync();
      // Pass flag follows the bypass write one cycle later, without waiting for the sync
      repeat (4) @(posedge clk_sys_i);
      chk("bypass", 32'(pas[c]), 32'h1);
    end
    chk("diff", {da, db, dbe}, {20'h0, 4'h0, 4'hf, 4'hf});
    bus(1'b1, IDX_OUT_MODE, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk("b_off", {dbe[0], db[0]}, 32'h0);
    bus(1'b1, IDX_OUT_MODE, 8'h11);
    repeat (2) @(posedge clk_sys_i);
    chk("b_on", {dbe[0], db[0]}, 32'h2);
    chk("b_rest", {dbe[3:1], db[3:1]}, 32'h3f);
    summarize();
  end
endmodule

bind ccdp_channel_divider ccdp_checker ccdp_checker_inst (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_req_i(avs_req_i), .avs_rsp_o(avs_rsp_o),
  .ch_level_o(ch_level_o), .ch_pass_o(ch_pass_o), .drv_a_o(drv_a_o), .drv_b_o(drv_b_o),
  .drv_b_en_o(drv_b_en_o), .duty_cycle_fix_o(duty_cycle_fix_o));
